// ---- common/tx_unpack_pkg.sv ----
// constants, field positions and state codes for the transmit buffer unpacker
`default_nettype none
package tx_unpack_pkg;
  // ****************************************************************
  // first command word fields
  // ****************************************************************
  localparam int          A_FS_BIT      = 13;
  localparam int          A_LS_BIT      = 12;
  localparam int          A_SIZE_MSB    = 10;
  localparam int          A_ALIGN_LO    = 24;
  localparam int          A_OFFS_LO     = 16;
  localparam logic [1:0]  ALIGN_4       = 2'h0;
  localparam logic [1:0]  ALIGN_16      = 2'h1;
  localparam logic [1:0]  ALIGN_32      = 2'h2;
  localparam logic [2:0]  MASK_16       = 3'h3;
  localparam logic [2:0]  MASK_32       = 3'h7;
  // ****************************************************************
  // second command word fields
  // ****************************************************************
  localparam int          B_TAG_LO      = 16;
  localparam int          B_CRC_DIS_BIT = 13;
  localparam int          B_PAD_DIS_BIT = 12;
  localparam int          B_LEN_MSB     = 10;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS   = 4'h4;
  localparam logic [3:0]  ADDR_PKTCNT   = 4'h8;
  localparam logic [3:0]  ADDR_TAG      = 4'hC;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam int          ST_ERR_BIT    = 0;
  localparam int          ST_BUSY_BIT   = 1;
  // ****************************************************************
  // unpacker states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_CMD_A = 3'b000,
    ST_CMD_B = 3'b001,
    ST_LEAD  = 3'b010,
    ST_DATA  = 3'b011,
    ST_EMIT  = 3'b100,
    ST_FILL  = 3'b101
  } unpack_state_t;
endpackage : tx_unpack_pkg
`default_nettype wire

// ---- design/tx_buffer_command_unpacker.sv ----
// transmit buffer command unpacker feeding the mac transmit buffer
//
// Behaviour
// R1: first command bit 13 marks first segment; a new packet starts there.
// R2: first command bit 12 marks last segment; packet closes after its payload.
// R3: first command bits 10:0 count payload bytes, excluding offset and fill.
// R4: byte count with end alignment gives trailing fill words, consumed silently.
// R5: running sum of buffer sizes compared to packet length; mismatch sets error.
// R6: second command bits 10:0 hold packet length; mismatch sets error flag.
// R7: second command tag bits 31:16 copied into the packet's status.
// R8: second command bit 13 suppresses automatic crc.
// R9: second command bit 12 suppresses padding of frames under 64 bytes.
// R10: with padding disabled the crc is always appended.
// R11: payload starts at the third word, after both command words.
// R12: offset low bits pick byte lane of first valid byte.
// R13: offset upper bits give up to 7 leading words, discarded.
// R14: payload may end on any byte; trailing bytes are not forwarded.
// R15: 4, 16 or 32 byte end fill is stripped.
// R16: host pads each buffer up to its chosen end alignment.
// R17: host keeps middle buffers at least 4 bytes long.
// R18: any start/end alignment and any first/last length is accepted.
// R19: mac transmit buffer holds a whole packet before sending.
// R20: host limits one packet to 2036 bytes of buffer space.
// R21: host may instead limit a packet to 86 buffers.
// R22: host writes zeros to reserved command bits.
// R23: second command stored only when first segment bit is set.
// R24: end alignment bits 25:24: 00 4, 01 16, 10 32, 11 reserved.
// R25: start offset bits 20:16 give 0 to 31 bytes.
// R26: after an error the transmitter keeps running.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_command_unpacker (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [31:0] fifo_word_i,
  input  wire logic        fifo_valid_i,
  output logic             fifo_ready_o,
  output logic [7:0]       mtb_byte_o,
  output logic             mtb_valid_o,
  output logic             mtb_first_o,
  output logic             mtb_end_o,
  output logic [15:0]      mtb_tag_o,
  output logic             mtb_crc_add_o,
  output logic             mtb_pad_en_o,
  output logic             tx_error_flag_o,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o
);
  // ****************************************************************
  // state and buffer bookkeeping
  // ****************************************************************
  tx_unpack_pkg::unpack_state_t state;
  tx_unpack_pkg::unpack_state_t next_state;
  logic        ctrl_en;
  logic        take;
  logic        done_buf;
  logic        fs_q;
  logic        ls_q;
  logic [10:0] size_q;
  logic [1:0]  lane;
  logic [2:0]  lead_q;
  logic [9:0]  dw_left;
  logic [2:0]  fill_q;
  logic [2:0]  cnt;
  logic [10:0] bytes_left;
  logic [31:0] word_q;
  logic [11:0] sum_q;
  logic [10:0] len_q;
  logic [15:0] tag_q;
  logic        crc_dis_q;
  logic        pad_dis_q;
  logic        pkt_first_q;
  logic        in_pkt;
  logic [15:0] pkt_cnt;

  // words after the offset words needed to hold lane + size bytes
  // a buffer that ends mid-word still costs that whole word
  function automatic logic [9:0] data_words(input logic [1:0] ln, input logic [10:0] sz);
    logic [12:0] total;
    total = 13'(ln) + 13'(sz) + 13'h3;
    return total[11:2];
  endfunction : data_words

  // fill words to reach the alignment; reserved code acts as 4-byte
  function automatic logic [2:0] fill_words(input logic [9:0] used, input logic [1:0] al);
    logic [2:0] mask;
    mask = (al == tx_unpack_pkg::ALIGN_16) ? tx_unpack_pkg::MASK_16 :
           (al == tx_unpack_pkg::ALIGN_32) ? tx_unpack_pkg::MASK_32 : 3'h0;
    return 3'(3'h0 - used[2:0]) & mask;
  endfunction : fill_words

  // where a buffer goes once the current stage is spent
  function automatic tx_unpack_pkg::unpack_state_t route(input logic [2:0] ld,
                                                        input logic [9:0] dw,
                                                        input logic [2:0] fl);
    if (ld != 3'h0) return tx_unpack_pkg::ST_LEAD;
    if (dw != 10'h0) return tx_unpack_pkg::ST_DATA;
    if (fl != 3'h0) return tx_unpack_pkg::ST_FILL;
    return tx_unpack_pkg::ST_CMD_A;
  endfunction : route

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    take = fifo_valid_i && fifo_ready_o;
    next_state = state;
    unique case (state)
      tx_unpack_pkg::ST_CMD_A: begin
        if (take) next_state = tx_unpack_pkg::ST_CMD_B;
      end
      tx_unpack_pkg::ST_CMD_B: begin
        if (take) next_state = route(lead_q, dw_left, fill_q); // R11
      end
      tx_unpack_pkg::ST_LEAD: begin
        if (take && cnt == 3'h1) next_state = route(3'h0, dw_left, fill_q); // R13
      end
      tx_unpack_pkg::ST_DATA: begin
        if (take) next_state = tx_unpack_pkg::ST_EMIT;
      end
      tx_unpack_pkg::ST_EMIT: begin
        if (bytes_left == 11'h1) next_state = route(3'h0, 10'h0, fill_q); // R14
        else if (lane == 2'h3) next_state = tx_unpack_pkg::ST_DATA;
      end
      tx_unpack_pkg::ST_FILL: begin
        if (take && cnt == 3'h1) next_state = tx_unpack_pkg::ST_CMD_A; // R15
      end
      default: next_state = tx_unpack_pkg::ST_CMD_A;
    endcase
    done_buf = (state != tx_unpack_pkg::ST_CMD_A) && (next_state == tx_unpack_pkg::ST_CMD_A);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= tx_unpack_pkg::ST_CMD_A;
      fifo_ready_o <= 1'b0;
    end else begin
      state <= next_state;
      // no word is taken while bytes of the held word are still going out
      // the error flag is status only; it never gates the word intake
      fifo_ready_o <= ctrl_en && (next_state != tx_unpack_pkg::ST_EMIT); // R26
    end
  end

  // ****************************************************************
  // first command word decode
  // ****************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fs_q <= 1'b0;
      ls_q <= 1'b0;
      size_q <= 11'h0;
      lead_q <= 3'h0;
      fill_q <= 3'h0;
    end else if (state == tx_unpack_pkg::ST_CMD_A && take) begin
      fs_q <= fifo_word_i[tx_unpack_pkg::A_FS_BIT]; // R1
      ls_q <= fifo_word_i[tx_unpack_pkg::A_LS_BIT]; // R2
      size_q <= fifo_word_i[tx_unpack_pkg::A_SIZE_MSB:0]; // R3
      lead_q <= fifo_word_i[tx_unpack_pkg::A_OFFS_LO+2 +: 3]; // R13 R25
      fill_q <= fill_words(10'(fifo_word_i[tx_unpack_pkg::A_OFFS_LO+2 +: 3]) +
                           data_words(fifo_word_i[tx_unpack_pkg::A_OFFS_LO +: 2],
                                      fifo_word_i[tx_unpack_pkg::A_SIZE_MSB:0]),
                           fifo_word_i[tx_unpack_pkg::A_ALIGN_LO +: 2]); // R4 R24
    end
  end

  // ****************************************************************
  // word and byte counters
  // ****************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lane <= 2'h0;
      dw_left <= 10'h0;
      bytes_left <= 11'h0;
      cnt <= 3'h0;
      word_q <= 32'h0;
    end else begin
      if (state == tx_unpack_pkg::ST_CMD_A && take) begin
        lane <= fifo_word_i[tx_unpack_pkg::A_OFFS_LO +: 2]; // R12
        dw_left <= data_words(fifo_word_i[tx_unpack_pkg::A_OFFS_LO +: 2],
                              fifo_word_i[tx_unpack_pkg::A_SIZE_MSB:0]); // R18
        bytes_left <= fifo_word_i[tx_unpack_pkg::A_SIZE_MSB:0];
      end
      if (state == tx_unpack_pkg::ST_CMD_B && take) begin
        cnt <= (lead_q != 3'h0) ? lead_q : fill_q;
      end else if (state == tx_unpack_pkg::ST_LEAD && take) begin
        cnt <= (cnt == 3'h1) ? fill_q : 3'(cnt - 3'h1);
      end else if (state == tx_unpack_pkg::ST_EMIT && next_state == tx_unpack_pkg::ST_FILL) begin
        cnt <= fill_q;
      end else if (state == tx_unpack_pkg::ST_FILL && take) begin
        cnt <= 3'(cnt - 3'h1);
      end
      if (state == tx_unpack_pkg::ST_DATA && take) begin
        word_q <= fifo_word_i;
        dw_left <= 10'(dw_left - 10'h1);
      end
      if (state == tx_unpack_pkg::ST_EMIT) begin
        lane <= 2'(lane + 2'h1);
        bytes_left <= 11'(bytes_left - 11'h1);
      end
    end
  end

  // ****************************************************************
  // second command word and packet totals
  // ****************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sum_q <= 12'h0;
      len_q <= 11'h0;
      tag_q <= 16'h0;
      crc_dis_q <= 1'b0;
      pad_dis_q <= 1'b0;
    end else if (state == tx_unpack_pkg::ST_CMD_B && take) begin
      if (fs_q) begin
        tag_q <= fifo_word_i[tx_unpack_pkg::B_TAG_LO +: 16]; // R7 R23
        crc_dis_q <= fifo_word_i[tx_unpack_pkg::B_CRC_DIS_BIT]; // R8
        pad_dis_q <= fifo_word_i[tx_unpack_pkg::B_PAD_DIS_BIT]; // R9
        len_q <= fifo_word_i[tx_unpack_pkg::B_LEN_MSB:0]; // R6
        sum_q <= 12'(size_q); // R5
      end else begin
        sum_q <= 12'(sum_q + 12'(size_q)); // R5
      end
    end
  end

  // ****************************************************************
  // mac transmit buffer side
  // ****************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mtb_byte_o <= 8'h0;
      mtb_valid_o <= 1'b0;
      mtb_first_o <= 1'b0;
      mtb_end_o <= 1'b0;
      mtb_tag_o <= 16'h0;
      mtb_crc_add_o <= 1'b0;
      mtb_pad_en_o <= 1'b0;
      pkt_first_q <= 1'b0;
    end else begin
      mtb_valid_o <= (state == tx_unpack_pkg::ST_EMIT); // R14
      mtb_byte_o <= word_q[{lane, 3'h0} +: 8];
      mtb_first_o <= (state == tx_unpack_pkg::ST_EMIT) && pkt_first_q;
      if (state == tx_unpack_pkg::ST_CMD_B && take && fs_q) begin
        pkt_first_q <= 1'b1; // R1
      end else if (state == tx_unpack_pkg::ST_EMIT) begin
        pkt_first_q <= 1'b0;
      end
      // end pulse commits the stored frame; the mac buffer sends only then
      mtb_end_o <= done_buf && ls_q; // R2 R19
      if (done_buf && ls_q) begin
        mtb_tag_o <= tag_q; // R7
        mtb_crc_add_o <= !crc_dis_q || pad_dis_q; // R8 R10
        mtb_pad_en_o <= !pad_dis_q; // R9
      end
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_en <= tx_unpack_pkg::CTRL_EN_RST;
      tx_error_flag_o <= 1'b0;
      in_pkt <= 1'b0;
      pkt_cnt <= 16'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == tx_unpack_pkg::ADDR_CTRL) ctrl_en <= reg_wdata_i[0];
      // sticky: only a write of one clears it, intake carries on regardless
      // a mismatch in the clearing cycle wins over the clear
      if (done_buf && ls_q && sum_q != 12'(len_q)) begin
        tx_error_flag_o <= 1'b1; // R5 R6
      end else if (reg_wr_i && reg_addr_i == tx_unpack_pkg::ADDR_STATUS &&
                   reg_wdata_i[tx_unpack_pkg::ST_ERR_BIT]) begin
        tx_error_flag_o <= 1'b0;
      end
      if (done_buf && ls_q) begin
        in_pkt <= 1'b0;
        pkt_cnt <= 16'(pkt_cnt + 16'h1);
      end else if (state == tx_unpack_pkg::ST_CMD_B && take && fs_q) begin
        in_pkt <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        tx_unpack_pkg::ADDR_CTRL:   reg_rdata_o <= {31'h0, ctrl_en};
        tx_unpack_pkg::ADDR_STATUS: reg_rdata_o <= {30'h0, in_pkt, tx_error_flag_o};
        tx_unpack_pkg::ADDR_PKTCNT: reg_rdata_o <= {16'h0, pkt_cnt};
        tx_unpack_pkg::ADDR_TAG:    reg_rdata_o <= {16'h0, mtb_tag_o};
        default:                    reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_first_cmd_b;
    state == tx_unpack_pkg::ST_CMD_B && take && fs_q;
  endsequence
  sequence s_pkt_close;
    done_buf && ls_q;
  endsequence

  a_first_opens_pkt: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
    s_first_cmd_b |=> pkt_first_q && in_pkt) else $error("first segment did not open packet");
  a_last_closes_pkt: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
    s_pkt_close |=> mtb_end_o) else $error("last segment did not close packet");
  a_len_mismatch_err: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
    s_pkt_close and (sum_q != 12'(len_q)) |=> tx_error_flag_o) else $error("length mismatch not flagged");
  a_tag_latched: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
    s_first_cmd_b |=> tag_q == $past(fifo_word_i[31:16])) else $error("tag not stored");
  a_crc_pad_ctl: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
    mtb_end_o |-> mtb_crc_add_o == (!crc_dis_q || pad_dis_q) && mtb_pad_en_o == !pad_dis_q)
    else $error("crc or pad control wrong");
  a_start_lane: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
    state == tx_unpack_pkg::ST_CMD_A && take |=> lane == $past(fifo_word_i[17:16]))
    else $error("start lane wrong");
  a_lead_dropped: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
    state == tx_unpack_pkg::ST_LEAD |=> !mtb_valid_o) else $error("leading word forwarded");
  a_fill_dropped: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R15
    state == tx_unpack_pkg::ST_FILL ##1 state == tx_unpack_pkg::ST_FILL |-> !mtb_valid_o)
    else $error("fill word forwarded");
  a_emit_stalls: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
    state == tx_unpack_pkg::ST_EMIT |-> !fifo_ready_o) else $error("word taken while emitting");
  // ready follows the enable one cycle late, so the enable is taken from the edge before
  a_err_keeps_run: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R26
    tx_error_flag_o && $past(ctrl_en) && state == tx_unpack_pkg::ST_CMD_A |-> fifo_ready_o)
    else $error("transmitter halted after error");
endmodule : tx_buffer_command_unpacker
`default_nettype wire

// ---- verification/tx_buffer_command_unpacker_tb.sv ----
// self-checking bench for the transmit buffer command unpacker
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_command_unpacker_tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        slow = 1'b0;
  logic [31:0] fifo_word;
  logic        fifo_valid, fifo_ready_o, mtb_valid_o, mtb_first_o, mtb_end_o;
  logic [7:0]  mtb_byte_o;
  logic [15:0] mtb_tag_o, last_tag, end_tag;
  logic        mtb_crc_add_o, mtb_pad_en_o, tx_error_flag_o, end_crc, end_pad, end_err;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [31:0] seed = 32'h0000E823;
  logic [7:0]  got[$], exp_q[$];
  int          firsts[$];
  int          ends, npkt = 0;
  int          fail_count = 0;
  int          checked = 0;

  initial forever #25 clk_i = ~clk_i;

  tx_host_model tx_host_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
    .fifo_ready_i(fifo_ready_o), .fifo_word_o(fifo_word), .fifo_valid_o(fifo_valid));

  tx_buffer_command_unpacker tx_buffer_command_unpacker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .fifo_word_i(fifo_word), .fifo_valid_i(fifo_valid), .fifo_ready_o(fifo_ready_o),
    .mtb_byte_o(mtb_byte_o), .mtb_valid_o(mtb_valid_o), .mtb_first_o(mtb_first_o), .mtb_end_o(mtb_end_o),
    .mtb_tag_o(mtb_tag_o), .mtb_crc_add_o(mtb_crc_add_o), .mtb_pad_en_o(mtb_pad_en_o),
    .tx_error_flag_o(tx_error_flag_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask : reg_read

  // byte and close capture at the sampling edge
  always @(posedge clk_i) begin
    if (mtb_valid_o === 1'b1) begin
      if (mtb_first_o === 1'b1)
        firsts.push_back(got.size());
      got.push_back(mtb_byte_o);
    end
    if (mtb_end_o === 1'b1) begin
      ends++;
      end_tag = mtb_tag_o;
      end_crc = mtb_crc_add_o;
      end_pad = mtb_pad_en_o;
      end_err = tx_error_flag_o;
    end
  end

  // later buffers carry a contradicting second word that must be ignored
  task automatic send_packet(input int nbuf, input bit bad, input logic cd, input logic pd, input bit corner,
                             input bit hold);
    logic [7:0]  pay[$];
    int          sz[$];
    int          total;
    int          cnt;
    logic [31:0] cmd_b;
    got.delete();
    exp_q.delete();
    firsts.delete();
    ends = 0;
    total = 0;
    for (int k = 0; k < nbuf; k++) begin
      sz.push_back(corner ? 1 : (k > 0 && k < nbuf - 1) ? 4 + rnd() % 37 : 1 + rnd() % 40);
      total += sz[k];
    end
    last_tag = 16'(rnd());
    cmd_b = {last_tag, 2'h0, cd, pd, 1'b0, 11'(total + int'(bad))};
    slow <= (rnd() % 2) == 1;
    if (hold)
      reg_write(tx_unpack_pkg::ADDR_CTRL, 32'h0);
    for (int k = 0; k < nbuf; k++) begin
      pay.delete();
      for (int i = 0; i < sz[k]; i++)
        pay.push_back(8'(rnd()));
      exp_q = {exp_q, pay};
      tx_host_model_i.send_buf(k == 0, k == nbuf - 1, corner ? 2'h2 : 2'(rnd() % 3), corner ? 5'h1F : 5'(rnd()),
                               k == 0 ? cmd_b : {~last_tag, 2'h0, ~cd, ~pd, 12'h0}, pay);
    end
    if (hold) begin
      repeat (20) @(posedge clk_i);
      check(got.size() == 0 && fifo_ready_o === 1'b0, "words taken while disabled");
      reg_write(tx_unpack_pkg::ADDR_CTRL, 32'h1);
    end
    cnt = 0;
    while (ends == 0 && cnt < 4000) begin
      @(posedge clk_i);
      cnt++;
    end
    @(negedge clk_i);
    check(ends == 1, "packet not closed once");
    check(got.size() == exp_q.size(), "forwarded byte count");
    for (int i = 0; i < got.size() && i < exp_q.size(); i++)
      check(got[i] === exp_q[i], "payload byte");
    check(firsts.size() == 1 && firsts[0] == 0, "first byte marker");
    check(end_tag === last_tag, "status tag");
    check(end_crc === (!cd || pd), "crc append control");
    check(end_pad === !pd, "pad control");
    check(end_err === bad, "error flag at close");
    npkt++;
  endtask : send_packet

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [3:0]  zr[4];
    zr = '{tx_unpack_pkg::ADDR_STATUS, tx_unpack_pkg::ADDR_PKTCNT, tx_unpack_pkg::ADDR_TAG, 4'h2};
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    reg_read(tx_unpack_pkg::ADDR_CTRL, d);
    check(d[0] === 1'b1, "enable after reset");
    foreach (zr[k]) begin
      reg_read(zr[k], d);
      check(d === 32'h0, "register not zero after reset");
    end
    reg_write(4'h2, 32'hFFFFFFFF);
    reg_read(tx_unpack_pkg::ADDR_CTRL, d);
    check(d[0] === 1'b1, "unmapped write disturbed control");
    send_packet(1, 0, 1'b0, 1'b0, 1, 0);
    for (int i = 0; i < 4; i++)
      send_packet(3, 0, i[1], i[0], 0, 0);
    send_packet(2, 1, 1'b0, 1'b0, 0, 0);
    reg_write(tx_unpack_pkg::ADDR_STATUS, 32'h1);
    reg_read(tx_unpack_pkg::ADDR_STATUS, d);
    check(d[0] === 1'b0, "error not cleared");
    send_packet(2, 0, 1'b0, 1'b1, 0, 0);
    send_packet(2, 0, 1'b1, 1'b0, 0, 1);
    repeat (20)
      send_packet(1 + rnd() % 4, 0, (rnd() % 2) == 1, (rnd() % 2) == 1, 0, 0);
    reg_read(tx_unpack_pkg::ADDR_PKTCNT, d);
    check(d[15:0] === 16'(npkt), "packet count");
    reg_read(tx_unpack_pkg::ADDR_TAG, d);
    check(d[15:0] === last_tag, "last tag register");
    give_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end
endmodule : tx_buffer_command_unpacker_tb
`default_nettype wire

// ---- verification/tx_host_model.sv ----
// host side model: builds transmit buffers and offers them to the unpacker word by word
`timescale 1ns/1ps
`default_nettype none
module tx_host_model (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        slow_i,
  input  wire logic        fifo_ready_i,
  output logic [31:0]      fifo_word_o,
  output logic             fifo_valid_o
);
  // ****************************************************************
  // buffer builder and word offer
  // ****************************************************************
  logic [31:0] pend[$];

  task automatic send_buf(input logic fs, input logic ls, input logic [1:0] al, input logic [4:0] offs,
                          input logic [31:0] cmd_b, input logic [7:0] pay[$]);
    logic [31:0] w;
    int          nw;
    int          fill;
    int          idx;
    nw = (int'(offs[1:0]) + pay.size() + 3) / 4;
    fill = (al == 2'h1) ? (4 - (offs[4:2] + nw) % 4) % 4 : (al == 2'h2) ? (8 - (offs[4:2] + nw) % 8) % 8 : 0;
    pend.push_back({6'h0, al, 3'h0, offs, 2'h0, fs, ls, 1'b0, 11'(pay.size())});
    pend.push_back(cmd_b);
    for (int i = 0; i < offs[4:2]; i++)
      pend.push_back(32'hDEAD0000 | i);
    for (int i = 0; i < nw; i++) begin
      for (int j = 0; j < 4; j++) begin
        idx = i * 4 + j - int'(offs[1:0]);
        // junk in unused lanes so a leaked lane shows up as a wrong byte
        w[j*8 +: 8] = (idx >= 0 && idx < pay.size()) ? pay[idx] : 8'h5A ^ 8'(idx);
      end
      pend.push_back(w);
    end
    for (int i = 0; i < fill; i++)
      pend.push_back(32'hF0F00000 | i);
  endtask : send_buf

  // word held until taken; an idle bus flips between the inverted and the true last word every cycle
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_valid_o <= 1'b0;
      fifo_word_o  <= 32'h0;
    end else if (!fifo_valid_o || fifo_ready_i) begin
      if (fifo_valid_o)
        void'(pend.pop_front());
      if (pend.size() > 0 && !(slow_i && fifo_valid_o)) begin
        fifo_valid_o <= 1'b1;
        fifo_word_o  <= pend[0];
      end else begin
        fifo_valid_o <= 1'b0;
        fifo_word_o  <= ~fifo_word_o;
      end
    end
  end
endmodule : tx_host_model
`default_nettype wire
